/* File: core/led_dim_pkg.sv */
// Purpose: Constants and types for the LED dimming configuration bank.
// Assumes: Byte-wide registers on a plain strobe port, read data one cycle later.
// Notes: Percentages are in tenths of a percent, gains in thousandths.
`default_nettype none
package led_dim_pkg;

    localparam logic [7:0] SLOPE_OFF = 8'h65;
    localparam logic [7:0] MODE_OFF = 8'h66;
    localparam logic [7:0] TRIM12_OFF = 8'h67;
    localparam logic [7:0] TRIM34_OFF = 8'h68;
    localparam logic [7:0] CTRL_OFF = 8'h70;
    localparam logic [7:0] STAT_OFF = 8'h71;

    localparam int SLOPE_POS = 5;
    localparam int RES_POS = 3;
    localparam int DITH_POS = 0;
    localparam int SWPT_POS = 4;
    localparam int RSET_POS = 3;
    localparam int SPLIT_POS = 2;
    localparam int SRC_POS = 0;
    localparam int TRIM_HI_POS = 4;
    localparam int TRIM_LO_POS = 0;
    localparam int HYB_POS = 0;
    localparam int SCALE_POS = 4;

    localparam logic [7:0] SLOPE_RST = 8'h00;
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] TRIM_RST = 8'h77;
    localparam logic [7:0] CTRL_RST = 8'h00;

    localparam logic [10:0] GAIN_UNITY = 11'h3E8;
    localparam logic [3:0] SMALL_LIMIT = 4'h0;

    typedef enum logic [1:0] {
        SRC_PIN_DUTY = 2'h0,
        SRC_DUTY_X_REG = 2'h1,
        SRC_REG = 2'h2,
        SRC_DIRECT = 2'h3
    } src_type;

    typedef struct packed {
        logic hybrid_active;
        logic [10:0] slope_gain;
        logic [9:0] switch_point;
        logic pwm_clk_valid;
        logic [5:0] pwm_clk_mhz;
        logic [2:0] dither_bits;
        src_type brightness_source;
        logic set_resistor_enable;
        logic [7:0] full_scale_ma;
        logic small_sink_enable;
    } dim_cfg_type;

    typedef struct packed {
        logic signed [7:0] ch4_current_trim;
        logic signed [7:0] ch3_current_trim;
        logic signed [7:0] ch2_current_trim;
        logic signed [7:0] ch1_current_trim;
    } trim_type;

endpackage
`default_nettype wire

/* File: core/led_dimming_config_bank.sv */
// Purpose: Dimming and current configuration bank driving PWM generator and sinks.
// Assumes: Measured duty, brightness level and current setting come from same-clock logic.
// Notes: Derived settings are registered, so they follow a write by two cycles, one after the stored register.
`timescale 1ns/1ps
`default_nettype none
module led_dimming_config_bank
(
    // Clock and reset.
    input wire logic core_clk,
    input wire logic sys_rst,
    // Register port.
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Brightness inputs.
    input wire logic pwm_in_pin,
    input wire logic frame_sync_active,
    input wire logic [15:0] measured_duty,
    input wire logic [15:0] brightness_level,
    input wire logic [15:0] current_setting,
    // Settings to the PWM generator and sinks.
    output led_dim_pkg::dim_cfg_type dim_cfg,
    output led_dim_pkg::trim_type sink_trim,
    output logic [15:0] brightness_value,
    output logic pwm_direct,
    output logic small_sink_active
);

    logic [7:0] slope_r;
    logic [7:0] mode_r;
    logic [7:0] trim12_r;
    logic [7:0] trim34_r;
    logic [7:0] ctrl_r;
    logic [7:0] rdata_r;
    logic pin_meta_r;
    logic pin_sync_r;
    led_dim_pkg::dim_cfg_type cfg_r;
    led_dim_pkg::trim_type trim_out_r;
    logic [15:0] bright_r;
    logic direct_r;
    logic small_r;

    // Gains in thousandths keep the slope multiplier free of fraction bits.
    function automatic logic [10:0] slope_gain(input logic [2:0] code);
        case (code)
            3'h0: slope_gain = 11'h3E8;
            3'h1: slope_gain = 11'h3FF;
            3'h2: slope_gain = 11'h417;
            3'h3: slope_gain = 11'h42E;
            3'h4: slope_gain = 11'h446;
            3'h5: slope_gain = 11'h45D;
            3'h6: slope_gain = 11'h475;
            default: slope_gain = 11'h48C;
        endcase
    endfunction

    // Switch points in tenths of a percent of full brightness.
    function automatic logic [9:0] switch_point(input logic [2:0] code);
        case (code)
            3'h0: switch_point = 10'h1F4;
            3'h1: switch_point = 10'h196;
            3'h2: switch_point = 10'h139;
            3'h3: switch_point = 10'h0FA;
            3'h4: switch_point = 10'h0DB;
            3'h5: switch_point = 10'h0BC;
            3'h6: switch_point = 10'h09C;
            default: switch_point = 10'h07D;
        endcase
    endfunction

    // Full-scale sink current in milliamperes for each scale code.
    function automatic logic [7:0] scale_ma(input logic [2:0] code);
        case (code)
            3'h0: scale_ma = 8'h19;
            3'h1: scale_ma = 8'h1E;
            3'h2: scale_ma = 8'h32;
            3'h3: scale_ma = 8'h3C;
            3'h4: scale_ma = 8'h50;
            3'h5: scale_ma = 8'h64;
            3'h6: scale_ma = 8'h78;
            default: scale_ma = 8'h96;
        endcase
    endfunction

    // Used once per channel, so the four sinks share one table.
    function automatic logic signed [7:0] trim_pct(input logic [3:0] code);
        case (code)
            4'h0: trim_pct = 8'sh41;
            4'h1: trim_pct = 8'sh38;
            4'h2: trim_pct = 8'sh2F;
            4'h3: trim_pct = 8'sh25;
            4'h4: trim_pct = 8'sh1C;
            4'h5: trim_pct = 8'sh13;
            4'h6: trim_pct = 8'sh09;
            4'h7: trim_pct = 8'sh00;
            4'h8: trim_pct = -8'sh09;
            4'h9: trim_pct = -8'sh13;
            4'hA: trim_pct = -8'sh1C;
            4'hB: trim_pct = -8'sh25;
            4'hC: trim_pct = -8'sh2F;
            4'hD: trim_pct = -8'sh38;
            4'hE: trim_pct = -8'sh41;
            default: trim_pct = -8'sh4A;
        endcase
    endfunction

    // Address decode.
    wire logic hit_slope = (reg_addr == led_dim_pkg::SLOPE_OFF);
    wire logic hit_mode = (reg_addr == led_dim_pkg::MODE_OFF);
    wire logic hit_trim12 = (reg_addr == led_dim_pkg::TRIM12_OFF);
    wire logic hit_trim34 = (reg_addr == led_dim_pkg::TRIM34_OFF);
    wire logic hit_ctrl = (reg_addr == led_dim_pkg::CTRL_OFF);
    wire logic hit_stat = (reg_addr == led_dim_pkg::STAT_OFF);

    // Field extraction.
    wire logic [2:0] slope_code = slope_r[led_dim_pkg::SLOPE_POS +: 3];
    wire logic [1:0] res_code = slope_r[led_dim_pkg::RES_POS +: 2];
    wire logic [2:0] dith_code = slope_r[led_dim_pkg::DITH_POS +: 3];

    wire logic [2:0] swpt_code = mode_r[led_dim_pkg::SWPT_POS +: 3];
    wire logic rset_en = mode_r[led_dim_pkg::RSET_POS];
    wire logic split_en = mode_r[led_dim_pkg::SPLIT_POS];
    wire logic [1:0] src_code = mode_r[led_dim_pkg::SRC_POS +: 2];

    // Hybrid enable and current scale live in the control register.
    wire logic hyb_en = ctrl_r[led_dim_pkg::HYB_POS];
    wire logic [2:0] scale_code = ctrl_r[led_dim_pkg::SCALE_POS +: 3];

    // One trim code per sink, two to a register.
    wire logic [3:0] ch1_code = trim12_r[led_dim_pkg::TRIM_LO_POS +: 4];
    wire logic [3:0] ch2_code = trim12_r[led_dim_pkg::TRIM_HI_POS +: 4];
    wire logic [3:0] ch3_code = trim34_r[led_dim_pkg::TRIM_LO_POS +: 4];
    wire logic [3:0] ch4_code = trim34_r[led_dim_pkg::TRIM_HI_POS +: 4];

    // Without hybrid mode the gain stays unity and no switch point exists.
    wire logic [10:0] gain_eff = hyb_en ? slope_gain(slope_code) : led_dim_pkg::GAIN_UNITY;
    wire logic [9:0] swpt_eff = hyb_en ? switch_point(swpt_code) : 10'h000;

    // The PLL multiplier only matters while frame sync is not steering the clock.
    wire logic clk_valid = ~frame_sync_active;
    wire logic [5:0] clk_mhz = clk_valid ? (6'h05 << res_code) : 6'h00;

    // Any code with its top bit set asks for the deepest dither.
    wire logic [2:0] dith_eff = dith_code[2] ? 3'h4 : dith_code;

    // When the resistor sets full scale the scale field is not a valid figure.
    wire logic [7:0] fs_ma = rset_en ? 8'h00 : scale_ma(scale_code);

    // The top nibble is zero exactly when the setting is under one sixteenth of full scale.
    wire logic small_nxt = split_en & (current_setting[15:12] == led_dim_pkg::SMALL_LIMIT);

    // Only the upper half is kept, so two full-scale inputs give just under full scale.
    wire logic [31:0] product = measured_duty * brightness_level;
    wire logic [15:0] product_hi = product[31:16];
    wire led_dim_pkg::src_type src = led_dim_pkg::src_type'(src_code);
    logic [15:0] bright_nxt;
    always_comb
    begin
        case (src)
            led_dim_pkg::SRC_PIN_DUTY: bright_nxt = measured_duty;
            led_dim_pkg::SRC_DUTY_X_REG: bright_nxt = product_hi;
            led_dim_pkg::SRC_REG: bright_nxt = brightness_level;
            default: bright_nxt = 16'h0000;
        endcase
    end
    // Passthrough uses the synchronised pin, so the sinks see the pin three cycles late.
    wire logic direct_nxt = (src == led_dim_pkg::SRC_DIRECT) & pin_sync_r;

    led_dim_pkg::dim_cfg_type cfg_nxt;
    always_comb
    begin
        cfg_nxt.hybrid_active = hyb_en;
        cfg_nxt.slope_gain = gain_eff;
        cfg_nxt.switch_point = swpt_eff;
        cfg_nxt.pwm_clk_valid = clk_valid;
        cfg_nxt.pwm_clk_mhz = clk_mhz;
        cfg_nxt.dither_bits = dith_eff;
        cfg_nxt.brightness_source = src;
        cfg_nxt.set_resistor_enable = rset_en;
        cfg_nxt.full_scale_ma = fs_ma;
        cfg_nxt.small_sink_enable = split_en;
    end

    led_dim_pkg::trim_type trim_nxt;
    always_comb
    begin
        trim_nxt.ch1_current_trim = trim_pct(ch1_code);
        trim_nxt.ch2_current_trim = trim_pct(ch2_code);
        trim_nxt.ch3_current_trim = trim_pct(ch3_code);
        trim_nxt.ch4_current_trim = trim_pct(ch4_code);
    end

    // Read mux; unmapped addresses read zero.
    wire logic [7:0] stat_word = {small_r, direct_r, hyb_en, 2'h0, dith_eff};
    wire logic [7:0] rdata_nxt =
        hit_slope ? slope_r :
        hit_mode ? {1'b0, mode_r[6:0]} :
        hit_trim12 ? trim12_r :
        hit_trim34 ? trim34_r :
        hit_ctrl ? ctrl_r :
        hit_stat ? stat_word : 8'h00;

    // Write enables, one per stored register; other addresses are ignored.
    wire logic wr_slope = reg_wr & hit_slope;
    wire logic wr_mode = reg_wr & hit_mode;
    wire logic wr_trim12 = reg_wr & hit_trim12;
    wire logic wr_trim34 = reg_wr & hit_trim34;
    wire logic wr_ctrl = reg_wr & hit_ctrl;

    // The reserved mode bit is never stored, so a stray one cannot reach the decode.
    wire logic [7:0] slope_nxt = wr_slope ? reg_wdata : slope_r;
    wire logic [7:0] mode_nxt = wr_mode ? {1'h0, reg_wdata[6:0]} : mode_r;
    wire logic [7:0] trim12_nxt = wr_trim12 ? reg_wdata : trim12_r;
    wire logic [7:0] trim34_nxt = wr_trim34 ? reg_wdata : trim34_r;
    wire logic [7:0] ctrl_nxt = wr_ctrl ? {1'h0, reg_wdata[6:4], 3'h0, reg_wdata[0]} : ctrl_r;

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            slope_r <= led_dim_pkg::SLOPE_RST;
            mode_r <= led_dim_pkg::MODE_RST;
            trim12_r <= led_dim_pkg::TRIM_RST;
            trim34_r <= led_dim_pkg::TRIM_RST;
            ctrl_r <= led_dim_pkg::CTRL_RST;
        end
        else
        begin
            slope_r <= slope_nxt;
            mode_r <= mode_nxt;
            trim12_r <= trim12_nxt;
            trim34_r <= trim34_nxt;
            ctrl_r <= ctrl_nxt;
        end
    end

    // Read data stands for one cycle and then returns to zero, so stale data never looks like an answer.
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            rdata_r <= 8'h00;
        else if (reg_rd)
            rdata_r <= rdata_nxt;
        else
            rdata_r <= 8'h00;
    end

    // The pin is asynchronous to core_clk.
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pin_meta_r <= 1'b0;
            pin_sync_r <= 1'b0;
        end
        else
        begin
            pin_meta_r <= pwm_in_pin;
            pin_sync_r <= pin_meta_r;
        end
    end

    // Settings change on writes, and the PWM clock fields also follow frame_sync_active, while brightness follows its inputs every cycle.
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cfg_r <= '0;
            trim_out_r <= '0;
        end
        else
        begin
            cfg_r <= cfg_nxt;
            trim_out_r <= trim_nxt;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            bright_r <= 16'h0000;
            direct_r <= 1'h0;
            small_r <= 1'h0;
        end
        else
        begin
            bright_r <= bright_nxt;
            direct_r <= direct_nxt;
            small_r <= small_nxt;
        end
    end

    assign reg_rdata = rdata_r;
    assign dim_cfg = cfg_r;
    assign sink_trim = trim_out_r;
    assign brightness_value = bright_r;
    assign pwm_direct = direct_r;
    assign small_sink_active = small_r;

endmodule // led_dimming_config_bank
`default_nettype wire

/* File: bench/led_dim_sva.sv */
// Purpose: Assertions on the dimming configuration bank ports.
// Assumes: Decoded outputs settle from the second edge after reset.
// Notes: The age counter masks the all-zero cycle that follows reset.
`timescale 1ns/1ps
`default_nettype none
module led_dim_sva
(
    // Clock and reset.
    input wire logic core_clk,
    input wire logic sys_rst,
    // Register port.
    input wire logic [7:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Brightness inputs.
    input wire logic frame_sync_active,
    input wire logic [15:0] brightness_level,
    input wire logic [15:0] current_setting,
    // Derived settings.
    input wire led_dim_pkg::dim_cfg_type dim_cfg,
    input wire logic [15:0] brightness_value,
    input wire logic pwm_direct,
    input wire logic small_sink_active
);
    logic [1:0] age_r;
    wire live = age_r[1];
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            age_r <= 2'h0;
        else if (!age_r[1])
            age_r <= age_r + 2'h1;
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    AST_GAIN: assert property (dim_cfg.hybrid_active |-> dim_cfg.slope_gain inside
        {11'h3E8, 11'h3FF, 11'h417, 11'h42E, 11'h446, 11'h45D, 11'h475, 11'h48C}) else $error("bad slope gain");
    AST_CLK: assert property (live |-> dim_cfg.pwm_clk_valid == !$past(frame_sync_active) &&
        (dim_cfg.pwm_clk_valid ? dim_cfg.pwm_clk_mhz inside {6'h05, 6'h0A, 6'h14, 6'h28} : dim_cfg.pwm_clk_mhz == 6'h00))
        else $error("bad pwm clock");
    AST_DITH: assert property (dim_cfg.dither_bits <= 3'h4) else $error("bad dither depth");
    AST_SWPT: assert property (dim_cfg.hybrid_active |-> dim_cfg.switch_point inside
        {10'h1F4, 10'h196, 10'h139, 10'h0FA, 10'h0DB, 10'h0BC, 10'h09C, 10'h07D}) else $error("bad switch point");
    AST_RSET: assert property (live |-> (dim_cfg.set_resistor_enable ? dim_cfg.full_scale_ma == 8'h00 :
        dim_cfg.full_scale_ma >= 8'h19)) else $error("bad full scale");
    AST_SMALL: assert property (live |-> small_sink_active ==
        (dim_cfg.small_sink_enable && $past(current_setting[15:12]) == 4'h0)) else $error("bad small sink");
    AST_SRC: assert property (live && dim_cfg.brightness_source == led_dim_pkg::SRC_REG |->
        brightness_value == $past(brightness_level)) else $error("bad register brightness");
    AST_PASS: assert property (dim_cfg.brightness_source != led_dim_pkg::SRC_DIRECT |-> !pwm_direct)
        else $error("passthrough outside direct mode");
    AST_HYB: assert property (live && !dim_cfg.hybrid_active |->
        dim_cfg.slope_gain == led_dim_pkg::GAIN_UNITY && dim_cfg.switch_point == 10'h000) else $error("hybrid off leak");
    AST_RSV: assert property (reg_rd && reg_addr == led_dim_pkg::MODE_OFF |=> !reg_rdata[7])
        else $error("reserved bit read set");
    cover property (dim_cfg.hybrid_active);
    cover property (small_sink_active);
    cover property (pwm_direct);
endmodule // led_dim_sva
bind led_dimming_config_bank led_dim_sva i_sva (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .frame_sync_active(frame_sync_active),
    .brightness_level(brightness_level), .current_setting(current_setting), .dim_cfg(dim_cfg),
    .brightness_value(brightness_value), .pwm_direct(pwm_direct), .small_sink_active(small_sink_active));
`default_nettype wire

/* File: bench/tb_top.sv */
// Purpose: Self-checking bench for the dimming configuration bank.
// Assumes: Derived outputs follow a write by two edges, reads by one.
// Notes: Waits are fixed counts because the block never stalls.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin failures++; \
    $display("BAD %s exp %0h got %0h", nm, e, g); end end
module tb_top;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, d;
    logic reg_wr = 1'b0, reg_rd = 1'b0, pwm_in_pin = 1'b0, frame_sync_active = 1'b0;
    logic [15:0] measured_duty = 16'h0000, brightness_level = 16'h0000, current_setting = 16'hFFFF;
    logic [15:0] brightness_value;
    logic pwm_direct, small_sink_active;
    led_dim_pkg::dim_cfg_type dim_cfg;
    led_dim_pkg::trim_type sink_trim;
    int failures = 0, tests_run = 0;
    logic [7:0] trim_tab [16] = '{8'h41, 8'h38, 8'h2F, 8'h25, 8'h1C, 8'h13, 8'h09, 8'h00,
        8'hF7, 8'hED, 8'hE4, 8'hDB, 8'hD1, 8'hC8, 8'hBF, 8'hB6};
    logic [10:0] gain_tab [8] = '{11'h3E8, 11'h3FF, 11'h417, 11'h42E, 11'h446, 11'h45D, 11'h475, 11'h48C};
    logic [9:0] swpt_tab [8] = '{10'h1F4, 10'h196, 10'h139, 10'h0FA, 10'h0DB, 10'h0BC, 10'h09C, 10'h07D};
    logic [15:0] src_tab [4] = '{16'h1234, 16'h091A, 16'h8000, 16'h0000};
    led_dimming_config_bank i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .pwm_in_pin(pwm_in_pin), .frame_sync_active(frame_sync_active), .measured_duty(measured_duty),
        .brightness_level(brightness_level), .current_setting(current_setting), .dim_cfg(dim_cfg),
        .sink_trim(sink_trim), .brightness_value(brightness_value), .pwm_direct(pwm_direct),
        .small_sink_active(small_sink_active));
    initial forever #5 core_clk = ~core_clk;
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    // Four edges cover the register update and the registered decode behind it, with margin.
    task automatic settle;
        repeat (4) @(posedge core_clk);
        #1;
    endtask
    task automatic t_reset;
        rd(8'h65); `CHK("slope_reg", 8'h00, d)
        rd(8'h66); `CHK("mode_reg", 8'h00, d)
        rd(8'h67); `CHK("trim12_reg", 8'h77, d)
        rd(8'h68); `CHK("trim34_reg", 8'h77, d)
        `CHK("trims", 32'h0, sink_trim)
        `CHK("gain", 11'h3E8, dim_cfg.slope_gain)
        `CHK("mhz", 6'h05, dim_cfg.pwm_clk_mhz)
        `CHK("full_scale", 8'h19, dim_cfg.full_scale_ma)
    endtask
    task automatic t_trim;
        for (int c = 0; c < 16; c++)
        begin
            wr(8'h67, {c[3:0], ~c[3:0]});
            wr(8'h68, {~c[3:0], c[3:0]});
            settle();
            `CHK("ch1", trim_tab[15 - c], 8'(sink_trim.ch1_current_trim))
            `CHK("ch2", trim_tab[c], 8'(sink_trim.ch2_current_trim))
            `CHK("ch3", trim_tab[c], 8'(sink_trim.ch3_current_trim))
            `CHK("ch4", trim_tab[15 - c], 8'(sink_trim.ch4_current_trim))
        end
        rd(8'h67); `CHK("trim12_back", 8'hF0, d)
    endtask
    task automatic t_slope;
        wr(8'h70, 8'h01);
        for (int i = 0; i < 8; i++)
        begin
            wr(8'h65, {i[2:0], i[1:0], i[2:0]});
            wr(8'h66, {1'b0, i[2:0], 4'h2});
            settle();
            `CHK("gain", gain_tab[i], dim_cfg.slope_gain)
            `CHK("mhz", 6'h05 << i[1:0], dim_cfg.pwm_clk_mhz)
            `CHK("dither", i[2] ? 3'h4 : i[2:0], dim_cfg.dither_bits)
            `CHK("switch", swpt_tab[i], dim_cfg.switch_point)
            `CHK("hybrid_on", 1'b1, dim_cfg.hybrid_active)
        end
        @(posedge core_clk);
        frame_sync_active <= 1'b1;
        wr(8'h70, 8'h00);
        settle();
        `CHK("gain_off", 11'h3E8, dim_cfg.slope_gain)
        `CHK("switch_off", 10'h000, dim_cfg.switch_point)
        `CHK("hybrid_off", 1'b0, dim_cfg.hybrid_active)
        `CHK("mhz_sync", 6'h00, dim_cfg.pwm_clk_mhz)
        `CHK("clk_valid", 1'b0, dim_cfg.pwm_clk_valid)
        @(posedge core_clk);
        frame_sync_active <= 1'b0;
    endtask
    task automatic t_mode;
        current_setting <= 16'h0FFF;
        wr(8'h66, 8'hFC);
        rd(8'h66); `CHK("mode_back", 8'h7C, d)
        settle();
        `CHK("fs_resistor", 8'h00, dim_cfg.full_scale_ma)
        `CHK("rset_flag", 1'b1, dim_cfg.set_resistor_enable)
        `CHK("split_flag", 1'b1, dim_cfg.small_sink_enable)
        `CHK("small_low", 1'b1, small_sink_active)
        @(posedge core_clk);
        current_setting <= 16'h1000;
        wr(8'h66, 8'h04);
        settle();
        `CHK("small_edge", 1'b0, small_sink_active)
        `CHK("fs_scale", 8'h19, dim_cfg.full_scale_ma)
        wr(8'h70, 8'h70);
        settle();
        `CHK("fs_scale7", 8'h96, dim_cfg.full_scale_ma)
        rd(8'h70); `CHK("ctrl_back", 8'h70, d)
        @(posedge core_clk);
        current_setting <= 16'h0FFF;
        wr(8'h66, 8'h00);
        settle();
        `CHK("small_off", 1'b0, small_sink_active)
    endtask
    task automatic t_src;
        @(posedge core_clk);
        measured_duty <= 16'h1234;
        brightness_level <= 16'h8000;
        pwm_in_pin <= 1'b1;
        for (int s = 0; s < 4; s++)
        begin
            wr(8'h66, {6'h00, s[1:0]});
            settle();
            `CHK("source", s[1:0], dim_cfg.brightness_source)
            `CHK("bright", src_tab[s], brightness_value)
            `CHK("direct", s == 3, pwm_direct)
        end
        rd(8'h71); `CHK("status", 8'h44, d)
        wr(8'h50, 8'hA5);
        rd(8'h50); `CHK("unmapped", 8'h00, d)
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // A hung run still reaches the verdict, counted as a mismatch.
    initial
    begin
        #200000;
        failures++;
        report_and_stop();
    end
    initial
    begin
        repeat (5) @(posedge core_clk);
        sys_rst <= 1'b0;
        t_reset();
        t_trim();
        t_slope();
        t_mode();
        t_src();
        report_and_stop();
    end
endmodule // tb_top
`default_nettype wire
